// [rtl/dcgo_calib.sv]
// Gain and offset arithmetic producing the final converter code
`timescale 1ns/100ps
module dcgo_calib #(
	parameter int W = 18
) (
	// Operands
	input  wire logic [W-1:0] inCode,
	input  wire logic         signedFmt,
	input  wire logic [W-1:0] gain,
	input  wire logic [W-1:0] offset,
	// Result
	output logic      [W-1:0] outCode
);
	logic [W-1:0]          uCode;
	logic [W:0]            gainP1;
	logic [2*W:0]          prod;
	logic signed [W+1:0]   sum;

	if (W < 2) begin : g_bad
		$error("dcgo_calib: W must be at least 2");
	end

	always_comb begin
		uCode = signedFmt ? {~inCode[W-1], inCode[W-2:0]} : inCode;
		gainP1 = {1'b0, gain} + {{W{1'b0}}, 1'b1};
		prod   = {{W{1'b0}}, uCode} * {{W{1'b0}}, gainP1};
		sum = $signed({1'b0, prod[2*W:W]}) + $signed({{2{offset[W-1]}}, offset});
		if (sum[W+1])
			outCode = '0;
		else if (sum[W])
			outCode = '1;
		else
			outCode = sum[W-1:0];
	end
endmodule : dcgo_calib

// [rtl/dcgo_defs.svh]
// Constants for the converter code, gain and offset register block
`ifndef DCGO_DEFS_SVH
`define DCGO_DEFS_SVH
`define DCGO_FRAME_BITS   5'h18
`define DCGO_CMD_BITS     5'h04
`define DCGO_READ_LAST    5'h16
`define DCGO_READ_FIRST   5'h05
`define DCGO_CMD_NOP      4'h0
`define DCGO_CMD_WR_CODE  4'h1
`define DCGO_CMD_WR_OFS   4'h2
`define DCGO_CMD_WR_GAIN  4'h3
`define DCGO_CMD_RD_CODE  4'h9
`define DCGO_CMD_RD_OFS   4'hA
`define DCGO_CMD_RD_GAIN  4'hB
`define DCGO_RST_CODE     18'h00000
`define DCGO_RST_OFS      18'h00000
`define DCGO_RST_GAIN     18'h3FFFF
`define DCGO_HALF_GAIN    18'h1FFFF
`define DCGO_MID_CODE     18'h20000
`define DCGO_QTR_CODE     18'h10000
`define DCGO_INIT_CYCLES  4'h8
`endif

// [rtl/dcgo_pkg.sv]
// Types shared by the converter register block
package dcgo_pkg;
	typedef logic [17:0] dcgo_word_t;
	typedef logic [3:0]  dcgo_cmd_t;
endpackage : dcgo_pkg

// [rtl/dcgo_regs.sv]
// Serial command decode, code/gain/offset registers and final code for the converter
`timescale 1ns/100ps
`include "dcgo_defs.svh"
module dcgo_regs (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Serial port pins
	input  wire logic              spiSclk,
	input  wire logic              spiCsN,
	input  wire logic              spiSdi,
	output logic                   spiSdo,
	output logic                   spiSdoEn,
	// Mode pins
	input  wire logic              codeFormatSelect,
	input  wire logic              powerUpScaleSelect,
	// Converter side
	output dcgo_pkg::dcgo_word_t   dacCode,
	output logic                   initDone
);
	import dcgo_pkg::*;

	localparam int NIN = 5;
	logic [NIN-1:0] syncA_q, syncB_q, syncC_q, filt_q, filt_d;
	logic [4:0]     bitCnt_q;
	logic [23:0]    shift_q;
	logic [23:0]    frameWord;
	logic           lastBit_q;
	logic           frameOn_q;
	dcgo_word_t     inputCode_q, offset_q, gain_q, calOut, rdData;
	dcgo_cmd_t      frameCmd;
	dcgo_cmd_t      rdCmd_q;
	dcgo_word_t     framePayload;
	logic [3:0]     initCnt_q;
	logic           initDone_q;
	logic           sclkFall, sclkRise, csFall, csRise, sdiBit, fmtSigned, scaleHigh;
	logic           execPulse, initLoad, rdActive;
	logic [4:0]     rdIdx;
	dcgo_word_t     dacCode_q;
	logic           spiSdo_q, spiSdoEn_q;

	// Three stages per pin; only stages two and three feed the filter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			syncA_q <= 5'h02;
			syncB_q <= 5'h02;
			syncC_q <= 5'h02;
		end else begin
			syncA_q <= {powerUpScaleSelect, codeFormatSelect, spiSdi, spiCsN, spiSclk};
			syncB_q <= syncA_q;
			syncC_q <= syncB_q;
		end
	end

	always_comb begin
		for (int i = 0; i < NIN; i++)
			filt_d[i] = (syncB_q[i] == syncC_q[i]) ? syncC_q[i] : filt_q[i];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			filt_q <= 5'h02;
		else
			filt_q <= filt_d;
	end

	assign sclkFall  = filt_q[0] & ~filt_d[0];
	assign sclkRise  = ~filt_q[0] & filt_d[0];
	assign csFall    = filt_q[1] & ~filt_d[1];
	assign csRise    = ~filt_q[1] & filt_d[1];
	assign sdiBit    = filt_d[2];
	assign fmtSigned = filt_q[3];
	assign scaleHigh = filt_q[4];

	assign frameWord    = {shift_q[22:0], sdiBit};
	assign frameCmd     = frameWord[23:20];
	assign framePayload = frameWord[19:2];
	assign execPulse    = sclkFall & frameOn_q & ~csRise & (bitCnt_q == `DCGO_FRAME_BITS - 5'h01);

	// Short frames simply never reach the execute count and are dropped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bitCnt_q  <= 5'h00;
			shift_q   <= 24'h000000;
			lastBit_q <= 1'b0;
			frameOn_q <= 1'b0;
		end else if (csFall) begin
			bitCnt_q  <= 5'h00;
			lastBit_q <= 1'b0;
			frameOn_q <= 1'b1;
		end else if (csRise) begin
			frameOn_q <= 1'b0;
		end else if (sclkFall && frameOn_q && bitCnt_q < `DCGO_FRAME_BITS) begin
			bitCnt_q  <= bitCnt_q + 5'h01;
			shift_q   <= frameWord;
			lastBit_q <= sdiBit;
		end
	end

	// Power-up defaults wait until the pin filters have settled
	assign initLoad = ~initDone_q & (initCnt_q == `DCGO_INIT_CYCLES - 4'h1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			initCnt_q  <= 4'h0;
			initDone_q <= 1'b0;
		end else if (!initDone_q) begin
			initCnt_q  <= initCnt_q + 4'h1;
			initDone_q <= initLoad;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			inputCode_q <= `DCGO_RST_CODE;
		end else if (initLoad) begin
			inputCode_q <= {scaleHigh ^ fmtSigned, 17'h00000};
		end else if (execPulse && frameCmd == `DCGO_CMD_WR_CODE) begin
			inputCode_q <= framePayload;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			offset_q <= `DCGO_RST_OFS;
		else if (execPulse && frameCmd == `DCGO_CMD_WR_OFS)
			offset_q <= framePayload;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			gain_q <= `DCGO_RST_GAIN;
		else if (execPulse && frameCmd == `DCGO_CMD_WR_GAIN)
			gain_q <= framePayload;
	end

	dcgo_calib #(
		.W (18)
	) u_calib (
		.inCode    (inputCode_q),
		.signedFmt (fmtSigned),
		.gain      (gain_q),
		.offset    (offset_q),
		.outCode   (calOut)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			dacCode_q <= `DCGO_RST_CODE;
		else
			dacCode_q <= calOut;
	end

	// Command kept apart, since the shift path moves past it after the fourth bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdCmd_q <= `DCGO_CMD_NOP;
		else if (csFall)
			rdCmd_q <= `DCGO_CMD_NOP;
		else if (sclkFall && frameOn_q && bitCnt_q == `DCGO_CMD_BITS - 5'h01)
			rdCmd_q <= frameWord[3:0];
	end

	always_comb begin
		unique case (rdCmd_q)
			`DCGO_CMD_RD_CODE: rdData = inputCode_q;
			`DCGO_CMD_RD_OFS:  rdData = offset_q;
			`DCGO_CMD_RD_GAIN: rdData = gain_q;
			default:           rdData = '0;
		endcase
	end

	assign rdIdx    = `DCGO_READ_LAST - bitCnt_q;
	// No-op, write and reserved commands keep echoing the input bits
	assign rdActive = (rdCmd_q == `DCGO_CMD_RD_CODE || rdCmd_q == `DCGO_CMD_RD_OFS || rdCmd_q == `DCGO_CMD_RD_GAIN)
		&& bitCnt_q >= `DCGO_READ_FIRST && bitCnt_q <= `DCGO_READ_LAST;

	// Output changes on the rising edge so the host samples it on the next fall
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			spiSdo_q   <= 1'b0;
			spiSdoEn_q <= 1'b0;
		end else begin
			spiSdoEn_q <= frameOn_q;
			if (csFall)
				spiSdo_q <= 1'b0;
			else if (sclkRise && frameOn_q)
				spiSdo_q <= rdActive ? rdData[rdIdx] : lastBit_q;
		end
	end

	assign spiSdo   = spiSdo_q;
	assign spiSdoEn = spiSdoEn_q;
	assign dacCode  = dacCode_q;
	assign initDone = initDone_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_NOP_HOLDS: assert property (execPulse && frameCmd == `DCGO_CMD_NOP |=>
		$stable(inputCode_q) && $stable(offset_q) && $stable(gain_q))
		else $error("no-op changed a register");
	AST_BINARY_UNITY: assert property (initDone_q && !fmtSigned && gain_q == `DCGO_RST_GAIN
		&& offset_q == 18'h00000 |=> dacCode_q == $past(inputCode_q))
		else $error("straight binary code not passed through");
	AST_SIGNED_UNITY: assert property (initDone_q && fmtSigned && gain_q == `DCGO_RST_GAIN
		&& offset_q == 18'h00000 |=> dacCode_q == ($past(inputCode_q) ^ `DCGO_MID_CODE))
		else $error("signed code not offset by midscale");
	AST_OFFSET_LOAD: assert property (execPulse && frameCmd == `DCGO_CMD_WR_OFS |=>
		offset_q == $past(framePayload))
		else $error("offset not loaded");
	AST_NEG_CLAMP: assert property (offset_q[17] && inputCode_q == 18'h00000 && !fmtSigned
		|=> dacCode_q == 18'h00000)
		else $error("negative offset not clamped at zero");
	AST_GAIN_LOAD: assert property (execPulse && frameCmd == `DCGO_CMD_WR_GAIN |=>
		gain_q == $past(framePayload))
		else $error("gain not loaded");
	AST_HALF_GAIN: assert property (gain_q == `DCGO_HALF_GAIN && offset_q == 18'h00000 && !fmtSigned
		&& inputCode_q == `DCGO_MID_CODE |=> dacCode_q == `DCGO_QTR_CODE)
		else $error("half gain wrong");
	AST_CODE_FRAME: assert property (execPulse && frameCmd == `DCGO_CMD_WR_CODE |=>
		inputCode_q == $past(shift_q[18:1]))
		else $error("code payload misplaced in frame");
	AST_POWERUP: assert property (initLoad |=>
		inputCode_q == (($past(scaleHigh) ^ $past(fmtSigned)) ? `DCGO_MID_CODE : 18'h00000) && initDone_q)
		else $error("power-up code wrong");
	AST_READBACK: assert property (sclkRise && frameOn_q && rdCmd_q == `DCGO_CMD_RD_OFS
		&& bitCnt_q == `DCGO_READ_FIRST |=> spiSdo_q == offset_q[17])
		else $error("offset readback sign bit wrong");
endmodule : dcgo_regs

// [verif/dcgo_regs_test.sv]
// Self-checking bench for the converter register block against a reference model
`timescale 1ns/100ps
module dcgo_regs_test;
	import dcgo_pkg::*;
	logic               clk, rst, spiSclk, spiCsN, spiSdi, spiSdo, spiSdoEn, initDone;
	logic               codeFormatSelect, powerUpScaleSelect;
	dcgo_word_t         dacCode;
	int                 failures, numChecks, cycles, codeM, ofsM, gainM;
	logic        [31:0] lfsrQ;
	logic        [21:0] dirTab [12] = '{22'h0DFFFF, 22'h060000, 22'h07FFFF, 22'h280000, 22'h09FFFF, 22'h040000,
		22'h0BFFFF, 22'h015555, 22'h0C0000, 22'h0A0000, 22'h2C0000, 22'h240000};
	dcgo_regs u_dut (.clk(clk), .rst(rst), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiSdi(spiSdi), .spiSdo(spiSdo),
		.spiSdoEn(spiSdoEn), .codeFormatSelect(codeFormatSelect), .powerUpScaleSelect(powerUpScaleSelect),
		.dacCode(dacCode), .initDone(initDone));
	dcgo_spi_host u_host (.clk(clk), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiSdi(spiSdi), .spiSdo(spiSdo),
		.spiSdoEn(spiSdoEn));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Cut a hang short well above the longest expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			failures++;
			finish_test();
		end
	end
	function automatic logic [31:0] lfsrNext(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsrNext
	function automatic int expCode();
		longint u;
		longint v;
		u = codeM ^ (codeFormatSelect ? 131072 : 0);
		v = (u * (gainM + 1)) >>> 18;
		v = v + ((ofsM >= 131072) ? ofsM - 262144 : ofsM);
		return (v < 0) ? 0 : (v > 262143) ? 262143 : int'(v);
	endfunction : expCode
	task automatic checkVal(input logic [22:0] got, input logic [22:0] exp, input string what);
		numChecks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : checkVal
	task automatic doReset(input logic pus);
		#1 rst = 1'b1;
		powerUpScaleSelect = pus;
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		repeat (12) @(posedge clk);
		#1;
		codeM = (pus ^ codeFormatSelect) ? 131072 : 0;
		ofsM = 0;
		gainM = 262143;
		checkVal(23'(initDone), 23'h1, "init done");
		checkVal(23'(dacCode), 23'(expCode()), "power-up code");
	endtask : doReset
	task automatic frame(input logic [21:0] cd, input int nBits);
		logic [22:0] expSdo;
		expSdo = {1'b0, cd};
		case (cd[21:18])
			4'h9: expSdo[17:0] = 18'(codeM);
			4'hA: expSdo[17:0] = 18'(ofsM);
			4'hB: expSdo[17:0] = 18'(gainM);
			default: ;
		endcase
		lfsrQ = lfsrNext(lfsrQ);
		u_host.sendFrame({cd, 2'b01}, nBits, lfsrQ[3] ? 9 : 5);
		if (nBits >= 24) begin
			case (cd[21:18])
				4'h1: codeM = cd[17:0];
				4'h2: ofsM = cd[17:0];
				4'h3: gainM = cd[17:0];
				default: ;
			endcase
			checkVal(u_host.rxBits[23:1], expSdo, "serial out");
			checkVal(23'(u_host.enLow), 23'h0, "enable in frame");
		end
		checkVal(23'(spiSdoEn), 23'h0, "enable idle");
		checkVal(23'(dacCode), 23'(expCode()), "code");
	endtask : frame
	initial begin
		rst = 1'b1;
		codeFormatSelect = 1'b0;
		powerUpScaleSelect = 1'b0;
		// Random source starts at 87937
		lfsrQ = 32'h00015781;
		for (int i = 0; i < 4; i++) begin
			codeFormatSelect = i[1];
			doReset(i[0]);
		end
		for (int i = 0; i < 24; i++) begin
			codeFormatSelect = i[0];
			frame(dirTab[i % 12], 24);
		end
		for (int i = 0; i < 64; i++) begin
			lfsrQ = lfsrNext(lfsrQ);
			codeFormatSelect = lfsrQ[7];
			// Every command including no-op, short and long frames
			frame({i[3:0], lfsrQ[25:8]}, (i % 7 == 3) ? 20 : (i % 5 == 1) ? 26 : 24);
		end
		finish_test();
	end
	task automatic finish_test();
		$display("Checks %0d failures %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
endmodule : dcgo_regs_test

// [verif/dcgo_spi_host.sv]
// SPI host model driving command frames into the register block
`timescale 1ns/100ps
module dcgo_spi_host (
	// Clock
	input  wire logic clk,
	// Serial port
	output logic      spiSclk,
	output logic      spiCsN,
	output logic      spiSdi,
	input  wire logic spiSdo,
	input  wire logic spiSdoEn
);
	logic [23:0] rxBits;
	int          enLow;
	initial begin
		spiSclk = 1'b0;
		spiCsN = 1'b1;
		spiSdi = 1'b0;
		rxBits = 24'h000000;
		enLow = 0;
	end
	task automatic waitClk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : waitClk
	task automatic sendFrame(input logic [23:0] frame, input int nBits, input int half);
		int k;
		rxBits = 24'h000000;
		enLow = 0;
		waitClk(1);
		spiCsN = 1'b0;
		waitClk(half);
		for (k = 0; k < nBits; k++) begin
			spiSdi = (k < 24) ? frame[23-k] : ~spiSdi;
			spiSclk = 1'b1;
			waitClk(half);
			if (k < 24)
				rxBits[23-k] = spiSdo;
			if (spiSdoEn !== 1'b1)
				enLow++;
			spiSclk = 1'b0;
			waitClk(half);
		end
		spiCsN = 1'b1;
		// Idle data line shows a changed level, not the last bit
		spiSdi = ~spiSdi;
		waitClk(8);
	endtask : sendFrame
endmodule : dcgo_spi_host
